// ===== pkg/slwr_pkg.sv
// shared constants and types of the supply loss and wake reporting block
package slwr_pkg;
  // default count of main power channels
  localparam int SLWR_N_POWER = 5;
  // bit positions of the synchronised input vector
  localparam int SLWR_IX_BAT   = 0;
  localparam int SLWR_IX_LOGIC = 1;
  localparam int SLWR_IX_RANGE = 2;
  localparam int SLWR_IX_GND   = 3;
  localparam int SLWR_IX_RST   = 4;
  localparam int SLWR_IX_CLK   = 5;
  localparam int SLWR_SYNC_W   = 6;
  // supply condition decided every cycle
  typedef enum logic [2:0] {
    ST_RUN        = 3'h0,
    ST_BAT_LOSS   = 3'h1,
    ST_LOGIC_LOSS = 3'h2,
    ST_POWER_OFF  = 3'h3,
    ST_GND_LOSS   = 3'h4
  } slwr_supply_t;
  // reset values and clock pin high level
  localparam slwr_supply_t SLWR_STATE_RESET = ST_POWER_OFF;
  localparam logic         SLWR_FLAG_RESET  = 1'h0;
  localparam logic         SLWR_SYNC_RESET  = 1'h0;
  localparam logic         SLWR_PIN_HIGH    = 1'h1;
endpackage

// ===== pkg/slwr_sync_if.sv
// carrier between the pin synchroniser and the block core
`timescale 1ns/1ns
`default_nettype none
interface slwr_sync_if #(
  parameter int WIDTH = 6
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport feed (output raw, input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ===== hdl/slwr_sync.sv
// two flip-flop synchroniser for asynchronous pins and comparators
`timescale 1ns/1ns
`default_nettype none
module slwr_sync #(
  parameter int WIDTH = 6
) (
  // clock, reset, enable
  input wire logic   mclk,
  input wire logic   sys_rst,
  input wire logic   clk_en,
  // raw in, synchronised out
  slwr_sync_if.sync  pins
);
  import slwr_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  generate
    if (WIDTH < 1)
    begin : g_check
      $error("slwr_sync: WIDTH must be at least one");
    end
  endgenerate

  // first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1 <= {WIDTH{SLWR_SYNC_RESET}};
      stage2 <= {WIDTH{SLWR_SYNC_RESET}};
    end
    else if (clk_en)
    begin
      stage1 <= pins.raw;
      stage2 <= stage1;
    end
  end

  // settled levels
  assign pins.synced = stage2;
endmodule
`default_nettype wire

// ===== hdl/slwr_top.sv
// supply loss decision and wake state reporting on the clock pin
// How it works
// - clock pin reports wake state only while host reset pin is held low.
// - awake with battery present, wake not from reset pin: clock pin is driven high.
// - asleep or woken by reset pin: clock pin undriven, input only.
// - operational only while wake is one; sleep while wake is zero.
// - no serial register readout while logic supply is absent.
// - both supplies lost: power off, all outputs off, all flags cleared.
// - battery lost, logic present: flags kept, five power outputs off.
// - battery lost, logic present: auxiliary output follows its configuration.
// - battery lost, logic present: serial reads kept while logic supply in range.
// - wake-up arriving during battery loss is not reported on clock pin.
// - logic supply lost with battery present: serial unavailable, watchdog timeout.
// - ground lost: five power outputs off.
// - serial errors and timeout enter fail mode; flag set on next transfer.
`timescale 1ns/1ns
`default_nettype none
module slwr_top #(
  parameter int N_POWER = slwr_pkg::SLWR_N_POWER
) (
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // supply comparators, asynchronous
  input  wire logic                  bat_pg,
  input  wire logic                  logic_pg,
  input  wire logic                  logic_in_range,
  input  wire logic                  gnd_ok,
  // host pins
  input  wire logic                  host_reset_n,
  input  wire logic                  clk_pin_in,
  output logic                       clk_pin_out,
  output logic                       clk_pin_oe,
  output logic                       clk_pin_level,
  // wake sources, same clock
  input  wire logic                  wake,
  input  wire logic                  wake_by_reset,
  // serial side, same clock
  input  wire logic                  serial_error,
  input  wire logic                  watchdog_expired,
  input  wire logic                  transfer_done,
  input  wire logic                  fail_exit,
  input  wire logic [N_POWER-1:0]    power_cfg,
  input  wire logic                  aux_cfg,
  // channel drive
  output logic [N_POWER-1:0]         power_outputs,
  output logic                       auxiliary_output,
  // supply and serial status
  output logic                       serial_read_en,
  output logic                       watchdog_timeout,
  output logic                       fail_mode,
  output logic                       serial_fail_flag,
  output logic                       register_clear,
  output logic                       operational,
  output logic                       sleep_mode,
  output slwr_pkg::slwr_supply_t     supply_state
);
  import slwr_pkg::*;

  generate
    if (N_POWER < 1)
    begin : g_check
      $error("slwr_top: N_POWER must be at least one");
    end
  endgenerate

  // supply decision, power off takes priority over every partial loss
  function automatic slwr_supply_t decode(input logic bat, input logic lgc, input logic gnd);
    if (!bat && !lgc)
      decode = ST_POWER_OFF;
    else if (!gnd)
      decode = ST_GND_LOSS;
    else if (!bat)
      decode = ST_BAT_LOSS;
    else if (!lgc)
      decode = ST_LOGIC_LOSS;
    else
      decode = ST_RUN;
  endfunction

  // pin synchroniser
  slwr_sync_if #(.WIDTH(SLWR_SYNC_W)) sync_bus ();

  logic [SLWR_SYNC_W-1:0] raw_pins;

  // gather asynchronous levels in synchroniser order, one driver for the vector
  always_comb
  begin
    raw_pins                = {SLWR_SYNC_W{SLWR_SYNC_RESET}};
    raw_pins[SLWR_IX_BAT]   = bat_pg;
    raw_pins[SLWR_IX_LOGIC] = logic_pg;
    raw_pins[SLWR_IX_RANGE] = logic_in_range;
    raw_pins[SLWR_IX_GND]   = gnd_ok;
    raw_pins[SLWR_IX_RST]   = host_reset_n;
    raw_pins[SLWR_IX_CLK]   = clk_pin_in;
  end

  assign sync_bus.raw = raw_pins;

  slwr_sync #(.WIDTH(SLWR_SYNC_W)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pins    (sync_bus.sync)
  );

  // named synchronised levels
  wire bat_s   = sync_bus.synced[SLWR_IX_BAT];
  wire logic_s = sync_bus.synced[SLWR_IX_LOGIC];
  wire range_s = sync_bus.synced[SLWR_IX_RANGE];
  wire gnd_s   = sync_bus.synced[SLWR_IX_GND];
  wire rst_n_s = sync_bus.synced[SLWR_IX_RST];
  wire clk_s   = sync_bus.synced[SLWR_IX_CLK];

  slwr_supply_t next_state;
  logic         wake_q;
  logic         wake_hidden;

  // supply decision from registered levels, every cycle
  assign next_state = decode(bat_s, logic_s, gnd_s);

  // decoded conditions
  wire run_ok       = (next_state == ST_RUN) && wake;
  wire aux_ok       = ((next_state == ST_RUN) || (next_state == ST_BAT_LOSS)) && wake;
  wire read_ok      = logic_s && range_s && (next_state != ST_POWER_OFF)
                      && (next_state != ST_LOGIC_LOSS);
  wire clear_now    = (next_state == ST_POWER_OFF);
  wire wd_entry     = (next_state == ST_LOGIC_LOSS) && (supply_state != ST_LOGIC_LOSS);
  wire fail_event   = serial_error || watchdog_expired || wd_entry;
  wire wake_rise    = wake && !wake_q;
  wire hide_rise    = wake_rise && !bat_s;
  wire hidden_next  = wake && (wake_hidden || hide_rise);
  wire report_ok    = !rst_n_s && wake && !wake_by_reset && bat_s && !hidden_next;
  wire fail_clear   = fail_exit && !fail_event && (next_state != ST_LOGIC_LOSS);
  wire [N_POWER-1:0] next_power = run_ok ? power_cfg : {N_POWER{1'h0}};

  // supply state register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      supply_state <= SLWR_STATE_RESET;
    else if (clk_en)
      supply_state <= next_state;
  end

  // channel drive, switched off in the same edge as the loss is decided
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      power_outputs    <= {N_POWER{1'h0}};
      auxiliary_output <= SLWR_FLAG_RESET;
    end
    else if (clk_en)
    begin
      power_outputs    <= next_power;
      auxiliary_output <= aux_ok && aux_cfg;
    end
  end

  // serial availability and clear level, high for the whole power off
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      serial_read_en   <= SLWR_FLAG_RESET;
      register_clear   <= !SLWR_FLAG_RESET;
      watchdog_timeout <= SLWR_FLAG_RESET;
    end
    else if (clk_en)
    begin
      serial_read_en   <= read_ok;
      register_clear   <= clear_now;
      watchdog_timeout <= wd_entry;
    end
  end

  // fail mode, a new error beats a simultaneous exit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      fail_mode <= SLWR_FLAG_RESET;
    else if (clk_en)
    begin
      if (clear_now)
        fail_mode <= SLWR_FLAG_RESET;
      else if (fail_event)
        fail_mode <= !SLWR_FLAG_RESET;
      else if (fail_clear)
        fail_mode <= SLWR_FLAG_RESET;
    end
  end

  // failure flag shows on the transfer after fail mode was entered
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      serial_fail_flag <= SLWR_FLAG_RESET;
    else if (clk_en)
    begin
      if (clear_now)
        serial_fail_flag <= SLWR_FLAG_RESET;
      else if (fail_mode && transfer_done)
        serial_fail_flag <= !SLWR_FLAG_RESET;
      else if (fail_clear)
        serial_fail_flag <= SLWR_FLAG_RESET;
    end
  end

  // wake edge tracking, a wake that began without battery stays hidden
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // starts high so a wake already present is no edge while syncs read zero
      wake_q      <= !SLWR_FLAG_RESET;
      wake_hidden <= SLWR_FLAG_RESET;
    end
    else if (clk_en)
    begin
      wake_q      <= wake;
      wake_hidden <= hidden_next;
    end
  end

  // clock pin drive and settled pin level
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      clk_pin_oe    <= SLWR_FLAG_RESET;
      clk_pin_out   <= SLWR_FLAG_RESET;
      clk_pin_level <= SLWR_FLAG_RESET;
    end
    else if (clk_en)
    begin
      clk_pin_oe    <= report_ok;
      clk_pin_out   <= report_ok ? SLWR_PIN_HIGH : SLWR_FLAG_RESET;
      clk_pin_level <= clk_s;
    end
  end

  // wake level gives run and sleep
  assign operational = wake;
  assign sleep_mode  = !wake;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence enter_logic_loss;
    clk_en && (decode(bat_s, logic_s, gnd_s) == ST_LOGIC_LOSS)
    && (supply_state != ST_LOGIC_LOSS);
  endsequence

  sequence rise_in_loss;
    clk_en && wake && !wake_q && !bat_s;
  endsequence

  sequence bat_loss_now;
    clk_en && (decode(bat_s, logic_s, gnd_s) == ST_BAT_LOSS);
  endsequence

  report_gate_a: assert property (clk_en && rst_n_s |=> !clk_pin_oe)
    else $error("clock pin driven while host reset released");
  report_high_a: assert property (clk_en && !rst_n_s && wake && !wake_by_reset && bat_s
                                  && !wake_hidden && wake_q |=> clk_pin_oe && clk_pin_out)
    else $error("awake state not reported high");
  reset_wake_a: assert property (clk_en && (wake_by_reset || !wake) |=> !clk_pin_oe)
    else $error("clock pin driven in sleep or reset wake");
  sleep_off_a: assert property (clk_en && !wake |=> (power_outputs == '0)
                                && !auxiliary_output)
    else $error("outputs left on in sleep");
  no_read_a: assert property (clk_en && !logic_s |=> !serial_read_en)
    else $error("serial read allowed without logic supply");
  power_off_a: assert property (clk_en && !bat_s && !logic_s |=> register_clear
                                && (power_outputs == '0) && !auxiliary_output
                                && !fail_mode && !serial_fail_flag)
    else $error("power off did not clear outputs and flags");
  bat_loss_keep_a: assert property (bat_loss_now and (fail_mode && !fail_exit)
                                    |=> fail_mode && (power_outputs == '0))
    else $error("battery loss lost flags or left outputs on");
  aux_follow_a: assert property (bat_loss_now |=> auxiliary_output == $past(aux_cfg && wake))
    else $error("auxiliary output ignores configuration");
  read_range_a: assert property (bat_loss_now and range_s |=> serial_read_en)
    else $error("serial read lost during battery loss");
  hidden_wake_a: assert property (rise_in_loss |=> !clk_pin_oe)
    else $error("wake during battery loss reported");
  logic_loss_a: assert property (enter_logic_loss |=> watchdog_timeout && fail_mode
                                 && !serial_read_en)
    else $error("logic supply loss missed watchdog timeout");
  wd_pulse_a: assert property (clk_en && watchdog_timeout |=> !watchdog_timeout)
    else $error("watchdog timeout longer than one cycle");
  gnd_loss_a: assert property (clk_en && !gnd_s |=> power_outputs == '0)
    else $error("power outputs on during ground loss");
  fail_flag_a: assert property (clk_en && fail_mode && transfer_done
                                && (bat_s || logic_s) |=> serial_fail_flag)
    else $error("failure flag not set on transfer");
  fail_set_a: assert property (clk_en && (serial_error || watchdog_expired)
                               && (decode(bat_s, logic_s, gnd_s) != ST_POWER_OFF) |=> fail_mode)
    else $error("serial error did not enter fail mode");
  decide_a: assert property (clk_en |=> supply_state == $past(decode(bat_s, logic_s, gnd_s)))
    else $error("supply state not decided from synced inputs");
  freeze_a: assert property (!clk_en |=> $stable(supply_state) && $stable(power_outputs)
                             && $stable(fail_mode))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ===== tb/slwr_host_model.sv
// host controller model driving the reset pin and sharing the clock pin
`timescale 1ns/1ns
`default_nettype none
module slwr_host_model (
  // clock and host intent
  input  wire logic mclk,
  input  wire logic reset_hold,
  // clock pin, device side
  input  wire logic clk_pin_out,
  input  wire logic clk_pin_oe,
  // pins as the device sees them
  output logic      host_reset_n,
  output logic      clk_pin_in,
  // wake state as read by the host
  output logic      wake_seen
);
  logic host_clk = 1'h0;

  // host clocks the pin only while it is not holding the device in reset
  always @(negedge mclk)
  begin
    host_clk <= reset_hold ? 1'h0 : ~host_clk;
  end

  // reset pin is active low
  assign host_reset_n = ~reset_hold;
  // wired pin level, pull-down when nobody drives
  assign clk_pin_in = clk_pin_oe ? clk_pin_out : (reset_hold ? 1'h0 : host_clk);
  // host reads the wake state only while reset is held
  assign wake_seen = reset_hold & clk_pin_in;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the supply loss and wake reporting block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import slwr_pkg::*;
  // stimulus
  logic       mclk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
  logic       bat_pg = 1'h1, logic_pg = 1'h1, logic_in_range = 1'h1, gnd_ok = 1'h1;
  logic       reset_hold = 1'h0, wake = 1'h1, wake_by_reset = 1'h0;
  logic       serial_error = 1'h0, watchdog_expired = 1'h0, transfer_done = 1'h0;
  logic       fail_exit = 1'h0, aux_cfg = 1'h1;
  logic [4:0] power_cfg = 5'h15;
  // observed
  wire  logic host_reset_n, clk_pin_in, wake_seen;
  logic       clk_pin_out, clk_pin_oe, auxiliary_output, serial_read_en;
  logic       watchdog_timeout, fail_mode, serial_fail_flag, register_clear;
  logic       operational, sleep_mode, clk_pin_level;
  logic [4:0] power_outputs;
  slwr_supply_t supply_state;
  // bookkeeping
  int         fail_count = 0, checks = 0, cycles = 0, wd_count;

  always #25 mclk = ~mclk;

  slwr_top #(.N_POWER(5)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bat_pg(bat_pg),
    .logic_pg(logic_pg), .logic_in_range(logic_in_range), .gnd_ok(gnd_ok),
    .host_reset_n(host_reset_n), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .clk_pin_level(clk_pin_level),
    .wake(wake), .wake_by_reset(wake_by_reset),
    .serial_error(serial_error), .watchdog_expired(watchdog_expired),
    .transfer_done(transfer_done), .fail_exit(fail_exit), .power_cfg(power_cfg),
    .aux_cfg(aux_cfg), .power_outputs(power_outputs), .auxiliary_output(auxiliary_output),
    .serial_read_en(serial_read_en), .watchdog_timeout(watchdog_timeout),
    .fail_mode(fail_mode), .serial_fail_flag(serial_fail_flag),
    .register_clear(register_clear), .operational(operational),
    .sleep_mode(sleep_mode), .supply_state(supply_state));

  slwr_host_model u_host (
    .mclk(mclk), .reset_hold(reset_hold), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .host_reset_n(host_reset_n), .clk_pin_in(clk_pin_in),
    .wake_seen(wake_seen));

  // comparisons
  task check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // pins need two sync flops plus one decision edge
  task settle;
    repeat (4) @(negedge mclk);
  endtask

  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // wake reporting on the clock pin
  task sc_wake;
    reset_hold = 1'h1;
    settle;
    check_bit("clk_pin_oe", 1'h1, clk_pin_oe);
    check_bit("wake_seen", 1'h1, wake_seen);
    repeat (2) @(negedge mclk);
    check_bit("clk_pin_level", 1'h1, clk_pin_level);
    wake_by_reset = 1'h1;
    settle;
    check_bit("clk_pin_oe", 1'h0, clk_pin_oe);
    check_bit("clk_pin_level", 1'h0, clk_pin_level);
    wake_by_reset = 1'h0;
    wake = 1'h0;
    settle;
    check_bit("clk_pin_oe", 1'h0, clk_pin_oe);
    check_bit("operational", 1'h0, operational);
    check_bit("sleep_mode", 1'h1, sleep_mode);
    check_val("power_outputs", 8'h00, {3'h0, power_outputs});
    wake = 1'h1;
    reset_hold = 1'h0;
    settle;
    check_bit("clk_pin_oe", 1'h0, clk_pin_oe);
    check_bit("operational", 1'h1, operational);
  endtask

  // normal run and serial fail mode
  task sc_run_fail;
    check_val("power_outputs", 8'h15, {3'h0, power_outputs});
    check_val("supply_state", 8'h00, 8'(supply_state));
    check_bit("serial_read_en", 1'h1, serial_read_en);
    clk_en = 1'h0;
    power_cfg = 5'h0A;
    @(negedge mclk);
    check_val("power_outputs", 8'h15, {3'h0, power_outputs});
    power_cfg = 5'h15;
    clk_en = 1'h1;
    serial_error = 1'h1;
    @(negedge mclk);
    serial_error = 1'h0;
    check_bit("fail_mode", 1'h1, fail_mode);
    check_bit("serial_fail_flag", 1'h0, serial_fail_flag);
    transfer_done = 1'h1;
    @(negedge mclk);
    transfer_done = 1'h0;
    check_bit("serial_fail_flag", 1'h1, serial_fail_flag);
  endtask

  // battery lost with logic supply present
  task sc_bat_loss;
    reset_hold = 1'h1;
    bat_pg = 1'h0;
    settle;
    check_val("supply_state", 8'h01, 8'(supply_state));
    check_val("power_outputs", 8'h00, {3'h0, power_outputs});
    check_bit("fail_mode", 1'h1, fail_mode);
    check_bit("serial_fail_flag", 1'h1, serial_fail_flag);
    check_bit("register_clear", 1'h0, register_clear);
    check_bit("auxiliary_output", 1'h1, auxiliary_output);
    check_bit("serial_read_en", 1'h1, serial_read_en);
    aux_cfg = 1'h0;
    logic_in_range = 1'h0;
    wake = 1'h0;
    settle;
    check_bit("auxiliary_output", 1'h0, auxiliary_output);
    check_bit("serial_read_en", 1'h0, serial_read_en);
    wake = 1'h1;
    settle;
    check_bit("clk_pin_oe", 1'h0, clk_pin_oe);
    check_bit("wake_seen", 1'h0, wake_seen);
    bat_pg = 1'h1;
    logic_in_range = 1'h1;
    aux_cfg = 1'h1;
    settle;
    check_bit("clk_pin_oe", 1'h0, clk_pin_oe);
    reset_hold = 1'h0;
    fail_exit = 1'h1;
    @(negedge mclk);
    fail_exit = 1'h0;
    check_bit("fail_mode", 1'h0, fail_mode);
    check_bit("serial_fail_flag", 1'h0, serial_fail_flag);
    settle;
  endtask

  // logic supply lost, then ground lost
  task sc_logic_gnd;
    logic_pg = 1'h0;
    wd_count = 0;
    repeat (6)
    begin
      @(negedge mclk);
      if (watchdog_timeout === 1'h1)
        wd_count++;
    end
    check_val("watchdog_pulses", 8'h01, 8'(wd_count));
    check_val("supply_state", 8'h02, 8'(supply_state));
    check_bit("serial_read_en", 1'h0, serial_read_en);
    check_bit("fail_mode", 1'h1, fail_mode);
    logic_pg = 1'h1;
    gnd_ok = 1'h0;
    settle;
    check_val("supply_state", 8'h04, 8'(supply_state));
    check_val("power_outputs", 8'h00, {3'h0, power_outputs});
    gnd_ok = 1'h1;
    settle;
    check_val("power_outputs", 8'h15, {3'h0, power_outputs});
  endtask

  // both supplies lost clears everything
  task sc_power_off;
    serial_error = 1'h1;
    @(negedge mclk);
    serial_error = 1'h0;
    transfer_done = 1'h1;
    @(negedge mclk);
    transfer_done = 1'h0;
    check_bit("serial_fail_flag", 1'h1, serial_fail_flag);
    bat_pg = 1'h0;
    logic_pg = 1'h0;
    settle;
    check_val("supply_state", 8'h03, 8'(supply_state));
    check_bit("serial_fail_flag", 1'h0, serial_fail_flag);
    check_bit("register_clear", 1'h1, register_clear);
    check_val("power_outputs", 8'h00, {3'h0, power_outputs});
    check_bit("auxiliary_output", 1'h0, auxiliary_output);
    check_bit("fail_mode", 1'h0, fail_mode);
    bat_pg = 1'h1;
    logic_pg = 1'h1;
    settle;
    check_bit("fail_mode", 1'h0, fail_mode);
    check_bit("register_clear", 1'h0, register_clear);
  endtask

  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'h0;
    settle;
    sc_wake;
    sc_run_fail;
    sc_bat_loss;
    sc_logic_gnd;
    sc_power_off;
    end_of_test;
  end
endmodule
`default_nettype wire
